// ### include/rcm_pkg.sv
package rcm_pkg;
  // output reset stretch: least time on the pin, in ns
  localparam int unsigned RST_OUT_MIN_NS = 30000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RST_OUT_CYC = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_W = 16;
  // cycles the pin latch stays ignored after our own drive ends
  localparam logic [1:0] RST_BLANK_CYC = 2'h3;

  // misc control register one layout
  localparam int unsigned MISC_SMS_BIT = 0;
  localparam int unsigned MISC_CP_LO_BIT = 1;
  localparam int unsigned MISC_CP_HI_BIT = 2;
  localparam int unsigned MISC_MCO_BIT = 5;
  localparam logic [7:0] MISC_RESET_VAL = 8'h00;

  // prescaler half-periods in oscillator cycles
  localparam logic [4:0] HALF_DIV2 = 5'h01;
  localparam logic [4:0] HALF_DIV4 = 5'h02;
  localparam logic [4:0] HALF_DIV8 = 5'h04;
  localparam logic [4:0] HALF_DIV16 = 5'h08;
  localparam logic [4:0] HALF_DIV32 = 5'h10;

  typedef struct packed {
    logic [7:0] wdata;
    logic we;
  } rcm_misc_wr_t;

  typedef struct packed {
    logic cpu_clk;
    logic cpu_clk_en;
    logic clk_out_level;
    logic clk_out_oe;
  } rcm_clk_out_t;
endpackage

// ### src/rcm_sync2.sv
// two-stage level synchroniser with synchronous reset to a set value
module rcm_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // first stage is read only by the second
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// ### src/rcm_reset_clock_manager.sv
// Overview of operation
// - The reset pin is an input plus an open-drain output with a weak pull-up that the board may pull low.
// - An external low on the reset pin is caught without the clock; reset is entered once the clock runs and the latch is synchronised.
// - A recognised external reset pulse, short or long, makes the device drive the pin low for the minimum output time.
// - Power-on and voltage-drop resets are told apart and the pin is held low while the supply is below threshold.
// - A watchdog underflow drives the pin low for at least the minimum output time.
// - The clock controller supplies the CPU clock and lets software choose a slow power-saving mode.
// - The prescaler is steered by two select bits and a slow mode bit in one control register.
// - One port pin can drive the CPU clock out, enabled by a clock-out bit in the same register.
// - Prescaler select, slow mode and clock output all live in one miscellaneous register.
// - Slow mode clear gives oscillator/2; set gives /4, /8, /16, /32 for codes 00, 10, 01, 11.
// - With clock-out set the CPU clock drives the port pin, otherwise the pin stays general-purpose.
module rcm_reset_clock_manager (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // low_voltage_detector and watchdog
  input wire logic lvd_below_n,
  input wire logic lvd_power_on,
  input wire logic wdg_underflow,
  // misc_control_register_one write port and readback
  input rcm_pkg::rcm_misc_wr_t misc_wr,
  output logic [7:0] misc_rdata,
  // clocks out
  output rcm_pkg::rcm_clk_out_t clk_o,
  // merged reset and cause
  output logic dev_rst,
  output logic [1:0] rst_cause,
  // port pin general-purpose ownership
  output logic port_pin_free
);
  localparam int unsigned STRETCH_CNT_W = rcm_pkg::STRETCH_W;
  localparam logic [STRETCH_CNT_W-1:0] STRETCH_LOAD = STRETCH_CNT_W'(rcm_pkg::RST_OUT_CYC);

  typedef enum logic [1:0] {RCM_CAUSE_NONE, RCM_CAUSE_EXT, RCM_CAUSE_LVD, RCM_CAUSE_WDG} rcm_cause_t;

  // asynchronous pin capture: a low sets the latch with no clock needed
  logic ext_seen_r;
  logic ext_clr;
  always_ff @(posedge sys_clk or negedge reset_pin_in) begin
    if (!reset_pin_in) begin
      ext_seen_r <= 1'b1;
    end else if (ext_clr) begin
      ext_seen_r <= 1'b0;
    end
  end

  // synchronised views of pin latch and detector
  logic ext_sync;
  logic lvd_low_sync;
  rcm_sync2 #(.RESET_VAL(1'b1)) u_sync_ext (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(ext_seen_r),
    .sync_out(ext_sync)
  );
  rcm_sync2 #(.RESET_VAL(1'b1)) u_sync_lvd (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(~lvd_below_n),
    .sync_out(lvd_low_sync)
  );
  logic por_sync;
  rcm_sync2 #(.RESET_VAL(1'b1)) u_sync_por (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(lvd_power_on),
    .sync_out(por_sync)
  );

  // stretch counter and reset merge
  logic [STRETCH_CNT_W-1:0] stretch_r;
  logic [STRETCH_CNT_W-1:0] stretch_nxt;
  logic pin_drive_r;
  logic pin_drive_nxt;
  logic dev_rst_r;
  logic dev_rst_nxt;
  logic [1:0] cause_r;
  logic [1:0] cause_nxt;
  logic clr_r;
  logic clr_nxt;
  logic [1:0] blank_r;
  logic [1:0] blank_nxt;
  logic ext_mask;
  logic ext_hit;

  // own drive reads back as a low pin, so the latch is ignored while we drive
  // and until the cleared latch has left the synchroniser; a board low in that
  // short window after release is missed
  always_comb begin
    stretch_nxt = stretch_r;
    cause_nxt = cause_r;
    ext_mask = pin_drive_r || (blank_r != 2'h0);
    ext_hit = ext_sync && !ext_mask;
    blank_nxt = (blank_r != 2'h0) ? blank_r - 2'h1 : 2'h0;
    if (pin_drive_r) begin
      blank_nxt = rcm_pkg::RST_BLANK_CYC;
    end
    clr_nxt = ext_hit || ext_mask; // latch re-arms once seen or while masked
    if (ext_hit) begin
      stretch_nxt = STRETCH_LOAD;
      cause_nxt = RCM_CAUSE_EXT;
    end else if (wdg_underflow) begin
      stretch_nxt = STRETCH_LOAD;
      cause_nxt = RCM_CAUSE_WDG;
    end else if (stretch_r != '0) begin
      stretch_nxt = stretch_r - 1'b1;
    end
    // power-on reports as its own code, a voltage drop as code 0
    if (lvd_low_sync) begin
      cause_nxt = por_sync ? RCM_CAUSE_LVD : RCM_CAUSE_NONE;
    end
    pin_drive_nxt = lvd_low_sync || (stretch_nxt != '0);
    dev_rst_nxt = pin_drive_nxt || ext_hit;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stretch_r <= STRETCH_LOAD;
      pin_drive_r <= 1'b1;
      dev_rst_r <= 1'b1;
      cause_r <= RCM_CAUSE_NONE;
      clr_r <= 1'b0;
      blank_r <= rcm_pkg::RST_BLANK_CYC;
    end else begin
      stretch_r <= stretch_nxt;
      pin_drive_r <= pin_drive_nxt;
      dev_rst_r <= dev_rst_nxt;
      cause_r <= cause_nxt;
      clr_r <= clr_nxt;
      blank_r <= blank_nxt;
    end
  end
  // clear comes from a flop; a pin still low keeps the latch set, set wins
  assign ext_clr = clr_r;

  // misc_control_register_one, cleared by the merged reset too
  logic [7:0] misc_r;
  logic [7:0] misc_nxt;
  always_comb begin
    misc_nxt = misc_r;
    if (dev_rst_r) begin
      misc_nxt = rcm_pkg::MISC_RESET_VAL;
    end else if (misc_wr.we) begin
      misc_nxt = misc_wr.wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      misc_r <= rcm_pkg::MISC_RESET_VAL;
    end else begin
      misc_r <= misc_nxt;
    end
  end

  // prescaler: toggle cpu clock every half period, enable pulse on rising phase
  logic slow_mode_select;
  logic prescaler_select_hi;
  logic prescaler_select_lo;
  logic clock_out_enable;
  logic [4:0] half_sel;
  assign slow_mode_select = misc_r[rcm_pkg::MISC_SMS_BIT];
  assign prescaler_select_hi = misc_r[rcm_pkg::MISC_CP_HI_BIT];
  assign prescaler_select_lo = misc_r[rcm_pkg::MISC_CP_LO_BIT];
  assign clock_out_enable = misc_r[rcm_pkg::MISC_MCO_BIT];

  always_comb begin
    half_sel = rcm_pkg::HALF_DIV2;
    if (slow_mode_select) begin
      unique case ({prescaler_select_lo, prescaler_select_hi})
        2'b00: half_sel = rcm_pkg::HALF_DIV4;
        2'b01: half_sel = rcm_pkg::HALF_DIV8;
        2'b10: half_sel = rcm_pkg::HALF_DIV16;
        2'b11: half_sel = rcm_pkg::HALF_DIV32;
      endcase
    end
  end

  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic cpu_clk_r;
  logic cpu_clk_nxt;
  logic cpu_en_r;
  logic cpu_en_nxt;
  logic mco_r;
  logic mco_nxt;
  logic mco_oe_r;
  logic mco_oe_nxt;
  logic free_r;
  logic free_nxt;
  always_comb begin
    div_nxt = div_r + 5'h01;
    cpu_clk_nxt = cpu_clk_r;
    cpu_en_nxt = 1'b0;
    // rate change applies to the half period in progress; no phase ends shorter than the new half period
    if (div_r + 5'h01 >= half_sel) begin
      div_nxt = 5'h00;
      cpu_clk_nxt = ~cpu_clk_r;
      cpu_en_nxt = ~cpu_clk_r;
    end
    mco_oe_nxt = clock_out_enable;
    free_nxt = ~clock_out_enable;
    mco_nxt = clock_out_enable & cpu_clk_nxt;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_r <= 5'h00;
      cpu_clk_r <= 1'b0;
      cpu_en_r <= 1'b0;
      mco_r <= 1'b0;
      mco_oe_r <= 1'b0;
      free_r <= 1'b1;
    end else begin
      div_r <= div_nxt;
      cpu_clk_r <= cpu_clk_nxt;
      cpu_en_r <= cpu_en_nxt;
      mco_r <= mco_nxt;
      mco_oe_r <= mco_oe_nxt;
      free_r <= free_nxt;
    end
  end

  // outputs straight from flops; open drain drives only low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = pin_drive_r;
  assign dev_rst = dev_rst_r;
  assign rst_cause = cause_r;
  assign misc_rdata = misc_r;
  assign port_pin_free = free_r;
  assign clk_o.cpu_clk = cpu_clk_r;
  assign clk_o.cpu_clk_en = cpu_en_r;
  assign clk_o.clk_out_level = mco_r;
  assign clk_o.clk_out_oe = mco_oe_r;
endmodule

// ### bench/rcm_board_model.sv
module rcm_board_model (
  // drive on the wire
  input wire logic dev_oe,
  input wire logic board_pull,
  // resolved level
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // weak pull-up loses to any party pulling low
  assign pin_level = !(dev_oe || board_pull);
endmodule

// ### bench/rcm_chk.sv
module rcm_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // pin and sources
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic lvd_below_n,
  input wire logic wdg_underflow,
  // register and outputs
  input wire rcm_pkg::rcm_misc_wr_t misc_wr,
  input wire logic [7:0] misc_rdata,
  input wire rcm_pkg::rcm_clk_out_t clk_o,
  input wire logic dev_rst,
  input wire logic [1:0] rst_cause,
  input wire logic port_pin_free
);
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // cycles of the current pin drive, cleared when it ends
  always_comb run_nxt = reset_pin_oe ? run_r + 16'h0001 : 16'h0000;
  always_ff @(posedge sys_clk) run_r <= srst ? 16'h0000 : run_nxt;
  // assertions
  wdg_drive_a: assert property (wdg_underflow |=> reset_pin_oe && dev_rst && rst_cause == 2'h3)
    else $error("watchdog reset not driven");
  stretch_len_a: assert property ($fell(reset_pin_oe) && (rst_cause == 2'h1 || rst_cause == 2'h3)
    |-> run_r >= rcm_pkg::RST_OUT_CYC)
    else $error("pin drive too short");
  ext_drive_a: assert property (!reset_pin_in [*6] |-> reset_pin_oe)
    else $error("low pin not stretched");
  lvd_hold_a: assert property (!lvd_below_n [*5] |-> reset_pin_oe && dev_rst)
    else $error("low supply not holding reset");
  rst_merge_a: assert property (reset_pin_oe |-> dev_rst)
    else $error("pin driven without internal reset");
  wr_take_a: assert property (misc_wr.we && !dev_rst |=> misc_rdata == $past(misc_wr.wdata))
    else $error("register write lost");
  pin_own_a: assert property ($stable(misc_rdata[5]) [*3] |->
    port_pin_free == !misc_rdata[5] && clk_o.clk_out_oe == misc_rdata[5])
    else $error("clock-out pin ownership wrong");
  clk_out_a: assert property (clk_o.clk_out_oe |-> clk_o.clk_out_level == clk_o.cpu_clk)
    else $error("clock-out pin not following cpu clock");
  div_two_a: assert property (clk_o.cpu_clk_en && !dev_rst && !misc_rdata[0] ##1
    (!misc_rdata[0] && !dev_rst) [*2] |-> clk_o.cpu_clk_en && !$past(clk_o.cpu_clk_en))
    else $error("normal mode clock not half rate");
  cover property (wdg_underflow);
  cover property ($fell(reset_pin_oe));
  cover property (misc_wr.we && misc_wr.wdata[0] && !dev_rst);
endmodule

bind rcm_reset_clock_manager rcm_chk i_chk (.sys_clk, .srst, .reset_pin_in, .reset_pin_oe,
  .lvd_below_n, .wdg_underflow, .misc_wr, .misc_rdata, .clk_o, .dev_rst, .rst_cause,
  .port_pin_free);

// ### bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic board_pull = 1'b0;
  logic lvd_below_n = 1'b1;
  logic lvd_power_on = 1'b0;
  logic wdg_underflow = 1'b0;
  rcm_pkg::rcm_misc_wr_t misc_wr = '0;
  rcm_pkg::rcm_clk_out_t clk_o;
  logic [7:0] misc_rdata;
  logic [1:0] cause;
  logic pin, oe, dev_rst, free;
  int fails = 0;
  int comparisons = 0;
  int n;
  // register value, cpu clock period in cycles
  logic [7:0] rows [6][2] = '{'{8'h00, 8'h02}, '{8'h01, 8'h04}, '{8'h05, 8'h08},
    '{8'h03, 8'h10}, '{8'h07, 8'h20}, '{8'h24, 8'h02}};

  always #2.5 sys_clk = ~sys_clk;

  rcm_reset_clock_manager i_dut (.sys_clk, .srst, .reset_pin_in(pin), .reset_pin_out(),
    .reset_pin_oe(oe), .lvd_below_n, .lvd_power_on, .wdg_underflow, .misc_wr, .misc_rdata,
    .clk_o, .dev_rst, .rst_cause(cause), .port_pin_free(free));
  rcm_board_model i_board (.dev_oe(oe), .board_pull, .pin_level(pin));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge sys_clk) misc_wr = {d, 1'b1};
    @(negedge sys_clk) misc_wr.we = 1'b0;
  endtask
  // bounded wait for the pin drive to end
  task automatic hold(output int c);
    c = 0;
    while (oe === 1'b1 && c < 8000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask
  // third wait is a whole period; the first may be cut by the write
  task automatic period(output int c);
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(negedge sys_clk);
        c++;
      end while (clk_o.cpu_clk_en !== 1'b1 && c < 100);
    end
  endtask

  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk(oe, 1'b1);
    wr(8'h07);
    chk(misc_rdata, 8'h00);
    hold(n);
    chk(dev_rst, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][0]);
      chk(misc_rdata, rows[i][0]);
      @(negedge sys_clk);
      chk(free, !rows[i][0][5]);
      chk(clk_o.clk_out_level, clk_o.cpu_clk & rows[i][0][5]);
      chk(clk_o.clk_out_oe, rows[i][0][5]);
      period(n);
      chk(16'(n), rows[i][1]);
    end
    @(negedge sys_clk) wdg_underflow = 1'b1;
    @(negedge sys_clk) wdg_underflow = 1'b0;
    chk(cause, 2'h3);
    hold(n);
    chk(16'(n), 16'(rcm_pkg::RST_OUT_CYC));
    chk(misc_rdata, 8'h00);
    // let the device stop ignoring the pin after its own drive
    repeat (4) @(negedge sys_clk);
    #0.5 board_pull = 1'b1;
    #1 board_pull = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(cause, 2'h1);
    hold(n);
    chk(n + 8 >= rcm_pkg::RST_OUT_CYC, 1'b1);
    lvd_below_n = 1'b0;
    lvd_power_on = 1'b1;
    repeat (7000) @(negedge sys_clk);
    chk({oe, cause}, 3'h6);
    lvd_below_n = 1'b1;
    hold(n);
    lvd_power_on = 1'b0;
    lvd_below_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({oe, cause}, 3'h4);
    lvd_below_n = 1'b1;
    hold(n);
    chk(dev_rst, 1'b0);
    final_report();
  end

  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule
